// *** acp_serial_port.sv ***
// ****************************************
// ****************************************
`default_nettype none
module acp_serial_port (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic program_mode_select,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic [13:0] core_data,
	output logic [13:0] lane_data,
	output logic lane_data_oe,
	output logic data_clock_oe,
	output logic frame_marker_oe,
	output logic [7:0] drive_current,
	output logic [4:0] serial_bits,
	output logic two_lanes,
	output var acp_pkg::acp_cfg_s cfg,
	output logic converter_sleep
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic sck_prev;
	logic [2:0] next_sync1;
	logic [2:0] next_sync2;

	// Two flops before anything looks at a pin
	always_comb begin
		next_sync1 = {cs_n, sck, sdi};
		next_sync2 = sync1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
			sck_prev <= 1'b1;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sck_prev <= sync2[1];
		end
	end

	logic cs_s;
	logic sck_s;
	logic sdi_s;
	logic sck_rise;
	logic sck_fall;
	logic mode_s;
	logic mode_m;
	assign cs_s = sync2[2];
	assign sck_s = sync2[1];
	assign sdi_s = sync2[0];
	assign sck_rise = sck_s & ~sck_prev;
	assign sck_fall = ~sck_s & sck_prev;

	// Mode select is a strap but still a pin: synchronise it too
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_m <= 1'b1;
			mode_s <= 1'b1;
		end else begin
			mode_m <= program_mode_select;
			mode_s <= mode_m;
		end
	end

	// ****************************************
	// Serial word engine
	// ****************************************
	acp_pkg::acp_state_e state;
	acp_pkg::acp_state_e next_state;
	logic [4:0] bit_cnt;
	logic [4:0] next_bit_cnt;
	logic [15:0] shreg;
	logic [15:0] next_shreg;
	logic [7:0] rd_sh;
	logic [7:0] next_rd_sh;
	logic rd_act;
	logic next_rd_act;
	logic [7:0] pwr;
	logic [7:0] next_pwr;
	logic [7:0] omode;
	logic [7:0] next_omode;
	logic swrst;
	logic next_swrst;
	logic active;

	// Register read decode; reset register is write-only
	function automatic logic [7:0] read_reg(input logic [6:0] a,
		input logic [7:0] p, input logic [7:0] o);
		case (a)
			acp_pkg::ADDR_POWER: read_reg = p;
			acp_pkg::ADDR_OUTMODE: read_reg = o;
			default: read_reg = acp_pkg::READ_ZERO;
		endcase
	endfunction

	assign active = ~mode_s & ~cs_s;

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_rd_sh = rd_sh;
		next_rd_act = rd_act;
		next_pwr = pwr;
		next_omode = omode;
		next_swrst = 1'b0;
		case (state)
			acp_pkg::ACP_IDLE: begin
				next_bit_cnt = '0;
				next_rd_act = 1'b0;
				if (active) begin
					next_state = acp_pkg::ACP_SHIFT;
				end
			end
			acp_pkg::ACP_SHIFT: begin
				if (!active) begin
					// Drop readback at once so a cut read frees the line
					next_state = acp_pkg::ACP_IDLE;
					next_rd_act = 1'b0;
				end else if (sck_rise) begin
					next_shreg = {shreg[14:0], sdi_s};
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt + 5'h01 == acp_pkg::HDR_BITS &&
						shreg[6]) begin
						next_rd_act = 1'b1;
						next_rd_sh = read_reg({shreg[5:0], sdi_s}, pwr,
							omode);
					end
					if (bit_cnt + 5'h01 == acp_pkg::WORD_BITS) begin
						next_state = acp_pkg::ACP_DONE;
					end
				end else if (sck_fall && rd_act &&
					bit_cnt > acp_pkg::HDR_BITS) begin
					next_rd_sh = {rd_sh[6:0], 1'b0};
				end
			end
			acp_pkg::ACP_DONE: begin
				// Later rising edges fall here and are ignored; a falling edge ends readback
				if (sck_fall && rd_act) begin
					next_rd_act = 1'b0;
				end
				if (!active) begin
					next_state = acp_pkg::ACP_IDLE;
					next_rd_act = 1'b0;
					if (!shreg[acp_pkg::DIR_POS + 8]) begin
						case (shreg[14:8])
							acp_pkg::ADDR_RESET:
								next_swrst = shreg[acp_pkg::SWRST_BIT];
							acp_pkg::ADDR_POWER: next_pwr = shreg[7:0];
							acp_pkg::ADDR_OUTMODE: next_omode = shreg[7:0];
							default: ;
						endcase
					end
				end
			end
			default: next_state = acp_pkg::ACP_IDLE;
		endcase
		if (swrst) begin
			next_pwr = acp_pkg::REG_RESET_VAL;
			next_omode = acp_pkg::REG_RESET_VAL;
		end
	end

	// Write commits at chip select rise so a short word never lands
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= acp_pkg::ACP_IDLE;
			bit_cnt <= '0;
			shreg <= '0;
			rd_sh <= '0;
			rd_act <= 1'b0;
			pwr <= acp_pkg::REG_RESET_VAL;
			omode <= acp_pkg::REG_RESET_VAL;
			swrst <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			rd_sh <= next_rd_sh;
			rd_act <= next_rd_act;
			pwr <= next_pwr;
			omode <= next_omode;
			swrst <= next_swrst;
		end
	end

	// ****************************************
	// Output decode
	// ****************************************
	logic [7:0] cur_base;
	logic [13:0] scr;
	logic [4:0] sbits;
	always_comb begin
		case (omode[acp_pkg::CUR_LSB +: 3])
			3'h0: cur_base = acp_pkg::CUR_3P5;
			3'h1: cur_base = acp_pkg::CUR_4P0;
			3'h2: cur_base = acp_pkg::CUR_4P5;
			3'h4: cur_base = acp_pkg::CUR_3P0;
			3'h5: cur_base = acp_pkg::CUR_2P5;
			3'h6: cur_base = acp_pkg::CUR_2P1;
			3'h7: cur_base = acp_pkg::CUR_1P75;
			default: cur_base = acp_pkg::CUR_NONE;
		endcase
		case (omode[acp_pkg::LANE_LSB +: 3])
			acp_pkg::LANE2_16, acp_pkg::LANE1_16: sbits = acp_pkg::SER_16;
			acp_pkg::LANE2_14, acp_pkg::LANE1_14: sbits = acp_pkg::SER_14;
			acp_pkg::LANE2_12, acp_pkg::LANE1_12: sbits = acp_pkg::SER_12;
			default: sbits = acp_pkg::SER_NONE;
		endcase
		scr = core_data;
		if (pwr[acp_pkg::SIGNED_BIT]) begin
			scr[13] = ~scr[13];
		end
		if (pwr[acp_pkg::SCRAMBLE_BIT]) begin
			scr[13:1] = scr[13:1] ^ {13{scr[0]}};
		end
	end

	// All outputs registered
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdo_out <= 1'b0;
			sdo_oe <= 1'b0;
			lane_data <= '0;
			lane_data_oe <= 1'b0;
			data_clock_oe <= 1'b0;
			frame_marker_oe <= 1'b0;
			drive_current <= acp_pkg::CUR_NONE;
			serial_bits <= acp_pkg::SER_NONE;
			two_lanes <= 1'b0;
			cfg <= '0;
			converter_sleep <= 1'b0;
		end else begin
			sdo_out <= 1'b0;
			sdo_oe <= next_rd_act & ~next_rd_sh[7];
			lane_data <= scr;
			lane_data_oe <= ~omode[acp_pkg::OFF_BIT];
			data_clock_oe <= ~omode[acp_pkg::OFF_BIT];
			frame_marker_oe <= ~omode[acp_pkg::OFF_BIT];
			drive_current <= omode[acp_pkg::TERM_BIT] ?
				{cur_base[6:0], 1'b0} : cur_base;
			serial_bits <= sbits;
			two_lanes <= ~omode[2];
			cfg <= {pwr[acp_pkg::DCS_BIT], pwr[acp_pkg::SCRAMBLE_BIT],
				pwr[acp_pkg::SIGNED_BIT], pwr[acp_pkg::SLEEP_BIT],
				pwr[acp_pkg::NAP_LSB +: acp_pkg::NAP_W], omode};
			converter_sleep <= pwr[acp_pkg::SLEEP_BIT] | swrst;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_write_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == acp_pkg::ACP_DONE && !active && !shreg[15] &&
		shreg[14:8] == acp_pkg::ADDR_POWER) |=> pwr == $past(shreg[7:0]))
		else $error("power write lost");
	a_read_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == acp_pkg::ACP_DONE && shreg[15] && !swrst) |=>
		$stable(pwr) && $stable(omode)) else $error("read changed reg");
	a_reset_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
		swrst |=> pwr == 8'h00 && omode == 8'h00 && !swrst)
		else $error("soft reset failed");
	a_reset_sleeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
		swrst |=> converter_sleep) else $error("no sleep on reset");
	a_cap_sixteen: assert property (@(posedge sys_clk) disable iff (!rst_n)
		bit_cnt <= acp_pkg::WORD_BITS) else $error("count over 16");
	a_cs_abort: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state != acp_pkg::ACP_IDLE && !active) |=>
		state == acp_pkg::ACP_IDLE) else $error("cs high ignored");
	a_sdo_drain: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sdo_oe |-> !sdo_out) else $error("sdo drove high");
	a_off_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
		omode[3] |=> !data_clock_oe && !frame_marker_oe)
		else $error("outputs not off");
	a_no_sdo_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == acp_pkg::ACP_IDLE) |=> !sdo_oe)
		else $error("sdo driven idle");

endmodule
`default_nettype wire

// *** acp_pkg.sv ***
`default_nettype none
package acp_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic [6:0] ADDR_POWER = 7'h01;
	localparam logic [6:0] ADDR_OUTMODE = 7'h02;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// Reset register field
	localparam int SWRST_BIT = 7;

	// Power-down register fields
	localparam int DCS_BIT = 7;
	localparam int SCRAMBLE_BIT = 6;
	localparam int SIGNED_BIT = 5;
	localparam int SLEEP_BIT = 4;
	localparam int NAP_LSB = 0;
	localparam int NAP_W = 4;

	// Output mode register fields
	localparam int CUR_LSB = 5;
	localparam int TERM_BIT = 4;
	localparam int OFF_BIT = 3;
	localparam int LANE_LSB = 0;

	// ****************************************
	// Serial word layout
	// ****************************************
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [4:0] HDR_BITS = 5'h08;
	localparam int DIR_POS = 7;

	// Drive current in units of 0.05 mA
	localparam logic [7:0] CUR_3P5 = 8'h46;
	localparam logic [7:0] CUR_4P0 = 8'h50;
	localparam logic [7:0] CUR_4P5 = 8'h5A;
	localparam logic [7:0] CUR_3P0 = 8'h3C;
	localparam logic [7:0] CUR_2P5 = 8'h32;
	localparam logic [7:0] CUR_2P1 = 8'h2A;
	localparam logic [7:0] CUR_1P75 = 8'h23;
	localparam logic [7:0] CUR_NONE = 8'h00;

	// Lane formats
	localparam logic [2:0] LANE2_16 = 3'h0;
	localparam logic [2:0] LANE2_14 = 3'h1;
	localparam logic [2:0] LANE2_12 = 3'h2;
	localparam logic [2:0] LANE1_14 = 3'h5;
	localparam logic [2:0] LANE1_12 = 3'h6;
	localparam logic [2:0] LANE1_16 = 3'h7;
	localparam logic [4:0] SER_16 = 5'h10;
	localparam logic [4:0] SER_14 = 5'h0E;
	localparam logic [4:0] SER_12 = 5'h0C;
	localparam logic [4:0] SER_NONE = 5'h00;

	typedef enum logic [2:0] {
		ACP_IDLE = 3'b001,
		ACP_SHIFT = 3'b010,
		ACP_DONE = 3'b100
	} acp_state_e;

	// Decoded configuration seen by the converter core
	typedef struct packed {
		logic duty_stabilizer_disable;
		logic output_scramble_enable;
		logic signed_format_select;
		logic sleep;
		logic [3:0] nap;
		logic [2:0] drive_current_select;
		logic internal_term_enable;
		logic output_drive_disable;
		logic [2:0] lane_format_select;
	} acp_cfg_s;

endpackage
`default_nettype wire

// *** acp_host_model.sv ***
`default_nettype none
module acp_host_model (
	input wire logic sys_clk,
	input wire logic sdo_line,
	output logic cs_n,
	output logic sck,
	output logic sdi
);
	timeunit 1ns;
	timeprecision 1ps;
	// Link idles with its clock low and chip select high
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	// One frame; bits past sixteen are filler, short counts abort
	// Clock is 3 cycles high, 5 low, so readback has time to settle
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		@(negedge sys_clk) cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk) sck = 1'b0;
			sdi = (i < 16) ? w[15 - i] : i[0];
			repeat (5) @(negedge sys_clk);
			if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line};
			sck = 1'b1;
			repeat (2) @(negedge sys_clk);
		end
		@(negedge sys_clk) sck = 1'b0;
		repeat (4) @(negedge sys_clk);
		cs_n = 1'b1;
		sdi = ~sdi;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// *** tb_adc_serial_config_port.sv ***
`default_nettype none
module tb_adc_serial_config_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_n, mode, cs_n, sck, sdi, sdo_out, sdo_oe;
	logic ld_oe, dc_oe, fr_oe, two_lanes, conv_sleep, seen_sleep;
	logic [13:0] core_data, lane_data;
	logic [7:0] drive_current, pwr, om, rd;
	logic [4:0] serial_bits;
	logic [31:0] seed;
	acp_pkg::acp_cfg_s cfg;
	int n_errors, checked, cyc;
	wire logic sdo_line;
	// Open drain with pull-up: released line reads high
	assign sdo_line = sdo_oe ? sdo_out : 1'b1;
	acp_serial_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.program_mode_select(mode), .cs_n(cs_n), .sck(sck), .sdi(sdi),
		.sdo_out(sdo_out), .sdo_oe(sdo_oe), .core_data(core_data),
		.lane_data(lane_data), .lane_data_oe(ld_oe),
		.data_clock_oe(dc_oe), .frame_marker_oe(fr_oe),
		.drive_current(drive_current), .serial_bits(serial_bits),
		.two_lanes(two_lanes), .cfg(cfg), .converter_sleep(conv_sleep));
	acp_host_model u_host (.sys_clk(sys_clk), .sdo_line(sdo_line),
		.cs_n(cs_n), .sck(sck), .sdi(sdi));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] exp_cur(input logic [7:0] o);
		logic [7:0] c;
		case (o[7:5])
			3'h0: c = acp_pkg::CUR_3P5;
			3'h1: c = acp_pkg::CUR_4P0;
			3'h2: c = acp_pkg::CUR_4P5;
			3'h4: c = acp_pkg::CUR_3P0;
			3'h5: c = acp_pkg::CUR_2P5;
			3'h6: c = acp_pkg::CUR_2P1;
			3'h7: c = acp_pkg::CUR_1P75;
			default: c = acp_pkg::CUR_NONE;
		endcase
		return o[4] ? {c[6:0], 1'b0} : c;
	endfunction
	function automatic logic [4:0] exp_ser(input logic [2:0] l);
		case (l)
			3'h0, 3'h7: return acp_pkg::SER_16;
			3'h1, 3'h5: return acp_pkg::SER_14;
			3'h2, 3'h6: return acp_pkg::SER_12;
			default: return acp_pkg::SER_NONE;
		endcase
	endfunction
	function automatic logic [13:0] exp_lane(input logic [13:0] d);
		logic [13:0] v;
		v = pwr[5] ? {~d[13], d[12:0]} : d;
		return pwr[6] ? {v[13:1] ^ {13{v[0]}}, v[0]} : v;
	endfunction
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Write with n clock pulses; the model follows only whole words
	task automatic wr(input logic [6:0] a, input logic [7:0] d,
		input int n);
		u_host.xfer({1'b0, a, d}, n, rd);
		if (!mode && n >= 16) begin
			if (a == acp_pkg::ADDR_RESET && d[7]) {pwr, om} = 16'h0000;
			else if (a == acp_pkg::ADDR_POWER) pwr = d;
			else if (a == acp_pkg::ADDR_OUTMODE) om = d;
		end
	endtask
	// Read with random filler data; also checks the register held
	task automatic rdchk(input logic [6:0] a);
		u_host.xfer({1'b1, a, 8'(rnd())}, 16, rd);
		check("readback", rd, a == 7'h01 ? pwr : a == 7'h02 ? om : 0);
	endtask
	task automatic chk_all();
		check("cfg", 16'(cfg), {pwr, om});
		check("current", drive_current, exp_cur(om));
		check("ser bits", serial_bits, exp_ser(om[2:0]));
		check("two lanes", two_lanes, om[2:0] < 3'h4);
		check("oe", {ld_oe, dc_oe, fr_oe}, {3{~om[3]}});
		check("sleep", conv_sleep, pwr[4]);
	endtask
	// ****************************************
	// Clock and timeout
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (conv_sleep) seen_sleep = 1'b1;
		if (cyc == 60000) begin
			n_errors++;
			wrap_up();
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'h1602B8B7;
		{rst_n, mode, core_data, pwr, om, seen_sleep} = '0;
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk_all();
		wr(7'h00, 8'h80, 16);
		chk_all();
		rdchk(7'h00);
		// Every current, termination and lane code
		for (int k = 0; k < 16; k++) begin
			wr(7'h02, {k[2:0], k[3], 1'b0, k[2:0]}, 16);
			chk_all();
		end
		// Random traffic: aborted, overlong and unmapped words
		for (int k = 0; k < 60; k++) begin
			wr(7'(rnd() % 4), 8'(rnd()),
				k % 5 == 0 ? int'(rnd() % 19) : 16);
			chk_all();
			rdchk(7'(rnd() % 4));
		end
		// Data formatting under each format and scramble setting
		for (int p = 0; p < 4; p++) begin
			wr(7'h01, {1'b0, p[1:0], 5'h00}, 16);
			for (int k = 0; k < 20; k++) begin
				core_data = 14'(rnd());
				@(negedge sys_clk);
				check("lane data", lane_data, exp_lane(core_data));
			end
		end
		// Parallel mode must leave the registers alone
		wr(7'h02, 8'h00, 16);
		mode = 1'b1;
		wr(7'h02, 8'h5D, 16);
		mode = 1'b0;
		repeat (4) @(negedge sys_clk);
		chk_all();
		// Soft reset in mid-run pulses converter sleep
		wr(7'h01, 8'h6F, 16);
		seen_sleep = 1'b0;
		wr(7'h00, 8'h80, 16);
		check("reset sleep", seen_sleep, 1'b1);
		chk_all();
		// Hardware reset in mid-run brings every register back to zero
		wr(7'h02, 8'hB9, 16);
		rst_n = 1'b0;
		{pwr, om} = 16'h0000;
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk_all();
		rdchk(7'h02);
		wrap_up();
	end
endmodule
`default_nettype wire
